// >>> flash_array_model.sv
// flash array stand-in answering auto operations with pass or a commanded failure
// assumes the controller holds its op strobe for the whole auto operation
`timescale 1ns/100ps
module flash_array_model (
  // clock
  input  wire clk,
  // controller side
  input  wire prog,
  input  wire erase,
  input  wire fail_req,
  output reg  array_fail
);
  initial array_fail = 1'b0;
  // toggles outside operations so a stale level is never trusted
  always @(posedge clk)
    if (prog || erase)
      array_fail <= fail_req;
    else
      array_fail <= ~array_fail;
endmodule // flash_array_model

// >>> flash_rewrite_control.v
// flash_rewrite_control: cpu-rewrite control/status registers and command sequencer
// assumes an axi4-lite master on clk; the flash array macro sits behind the array_* ports
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "flash_rewrite_defines.vh"

module flash_rewrite_control #(
  parameter NUM_BLOCKS  = 8,
  parameter PROG_CYCLES = `FRC_PROG_TIME_US * `FRC_CLK_MHZ,
  parameter ERASE_CYCLES = `FRC_ERASE_TIME_US * `FRC_CLK_MHZ
) (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [13:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [13:0] s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // power mode inputs from the clock controller
  input  wire        stop_wait_mode,
  // flash array side
  output reg         array_prog_q,
  output reg         array_erase_q,
  output reg  [15:0] array_addr_q,
  output reg  [7:0]  array_data_q,
  input  wire        array_fail,
  output wire        flash_access_en,
  output wire        flash_power_en,
  output wire        flash_low_current,
  output wire        cpu_hold,
  output wire        read_status_mode
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_PROG2 = 2'd1;
  localparam [1:0] ST_ERAS2 = 2'd2;
  localparam [1:0] ST_BUSY  = 2'd3;

  // control bits
  reg        ena_q;
  reg        unlk_q;
  reg        stop_q;
  reg        sel_q;
  reg        lk0_q;
  reg        lk1_q;
  reg        lk0_arm_q;
  reg        lk1_arm_q;
  reg        perr_q;
  reg        eerr_q;
  reg        rsr_q;
  reg        op_erase_q;
  reg [1:0]  st_q;
  reg [15:0] cnt_q;
  reg        fail_s1_q;
  reg        fail_q;
  reg        sw_s1_q;
  reg        sw_q;

  // axi write path: take address and data in either order, answer once both are held
  reg        aw_have_q;
  reg        w_have_q;
  reg [13:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        ar_have_q;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire [13:0] wa     = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : aw_addr_q;
  wire [31:0] wd     = s_axi_wvalid && s_axi_wready ? s_axi_wdata : w_data_q;
  wire [3:0]  ws     = s_axi_wvalid && s_axi_wready ? s_axi_wstrb : w_strb_q;
  wire        aw_ok  = aw_have_q || (s_axi_awvalid && s_axi_awready);
  wire        w_ok   = w_have_q || (s_axi_wvalid && s_axi_wready);
  wire        wr_go  = aw_ok && w_ok && !s_axi_bvalid;
  wire        lane0  = ws[0];
  wire [7:0]  wb     = wd[7:0];
  wire        wr_stat = wr_go && lane0 && (wa == `FRC_STAT_ADDR);
  wire        wr_mode = wr_go && lane0 && (wa == `FRC_MODE_ADDR);
  // command word: address in [31:16], command/data byte in [7:0]
  wire        wr_cmd  = wr_go && lane0 && (wa == `FRC_CMD_ADDR);
  wire [15:0] cmd_addr = wd[31:16];
  wire        mapped  = (wa == `FRC_STAT_ADDR) || (wa == `FRC_MODE_ADDR) || (wa == `FRC_CMD_ADDR);

  // block protection decode
  wire [15:0] blk      = cmd_addr >> `FRC_BLK_SHIFT;
  wire        in_range = blk < NUM_BLOCKS;
  wire        blk_ok   = (blk == 16'h0000) ? (unlk_q && !lk0_q) :
                         (blk == 16'h0001) ? (unlk_q && !lk1_q) :
                         1'b1;
  wire        busy     = (st_q == ST_BUSY);
  // stop blocks commands; rewrite enable gates them
  wire        cmd_live = wr_cmd && ena_q && !stop_q && !busy;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 14'h0000;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped ? 2'b00 : 2'b10;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_have_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_have_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
      end
    end
  end

  // read path: one cycle from address to data
  wire [7:0] stat_rd = {eerr_q, perr_q, 2'b00, stop_q, unlk_q, ena_q, !busy};
  wire [7:0] mode_rd = {1'b1, lk1_q, lk0_q, 3'b000, sel_q, 1'b0};

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
      ar_have_q    <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      ar_have_q    <= 1'b1;
      if (s_axi_araddr == `FRC_STAT_ADDR)
      begin
        s_axi_rdata <= {24'h000000, stat_rd};
        s_axi_rresp <= 2'b00;
      end
      else if (s_axi_araddr == `FRC_MODE_ADDR)
      begin
        s_axi_rdata <= {24'h000000, mode_rd};
        s_axi_rresp <= 2'b00;
      end
      else if (s_axi_araddr == `FRC_CMD_ADDR)
      begin
        s_axi_rdata <= {24'h000000, rsr_q ? {eerr_q, perr_q, 6'h00} : 8'h00};
        s_axi_rresp <= 2'b00;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'b10;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      ar_have_q    <= 1'b0;
    end
  end

  // async inputs: two-flop synchronisers
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fail_s1_q <= 1'b0;
      fail_q    <= 1'b0;
      sw_s1_q   <= 1'b0;
      sw_q      <= 1'b0;
    end
    else
    begin
      fail_s1_q <= array_fail;
      fail_q    <= fail_s1_q;
      sw_s1_q   <= stop_wait_mode;
      sw_q      <= sw_s1_q;
    end
  end

  // control registers
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ena_q     <= 1'b0;
      unlk_q    <= 1'b0;
      stop_q    <= 1'b0;
      sel_q     <= 1'b0;
      lk0_q     <= 1'b1;
      lk1_q     <= 1'b1;
      lk0_arm_q <= 1'b0;
      lk1_arm_q <= 1'b0;
    end
    else
    begin
      if (wr_stat)
      begin
        ena_q  <= wb[`FRC_ENA_BIT];
        unlk_q <= wb[`FRC_UNLK_BIT] && wb[`FRC_ENA_BIT];
        stop_q <= wb[`FRC_STOP_BIT];
        if (!wb[`FRC_ENA_BIT])
        begin
          sel_q <= 1'b0;
          lk0_q <= 1'b0;
          lk1_q <= 1'b0;
        end
      end
      if (wr_mode && ena_q)
      begin
        sel_q     <= wb[`FRC_SEL_BIT];
        // lock set by one write of 1; clear needs 1 then 0 in the next write
        lk0_arm_q <= wb[`FRC_LK0_BIT];
        lk1_arm_q <= wb[`FRC_LK1_BIT];
        if (wb[`FRC_LK0_BIT])
          lk0_q <= 1'b1;
        else if (lk0_arm_q)
          lk0_q <= 1'b0;
        if (wb[`FRC_LK1_BIT])
          lk1_q <= 1'b1;
        else if (lk1_arm_q)
          lk1_q <= 1'b0;
      end
      else if (wr_mode || wr_stat)
      begin
        lk0_arm_q <= 1'b0;
        lk1_arm_q <= 1'b0;
      end
    end
  end

  // command sequencer and error flags
  wire [7:0] pe_done = (cnt_q == 16'h0001) ? 8'h01 : 8'h00;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q          <= ST_IDLE;
      cnt_q         <= 16'h0000;
      perr_q        <= 1'b0;
      eerr_q        <= 1'b0;
      rsr_q         <= 1'b0;
      op_erase_q    <= 1'b0;
      array_prog_q  <= 1'b0;
      array_erase_q <= 1'b0;
      array_addr_q  <= 16'h0000;
      array_data_q  <= 8'h00;
    end
    else if (stop_q)
    begin
      // flash stop re-initialises the sequencer and aborts any operation
      st_q          <= ST_IDLE;
      cnt_q         <= 16'h0000;
      rsr_q         <= 1'b0;
      array_prog_q  <= 1'b0;
      array_erase_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (cmd_live)
          begin
            if (wb == `FRC_CMD_PROG)
              st_q <= ST_PROG2;
            else if (wb == `FRC_CMD_ERASE)
              st_q <= ST_ERAS2;
            else if (wb == `FRC_CMD_STATUS)
              rsr_q <= 1'b1;
            else if (wb == `FRC_CMD_READ)
              rsr_q <= 1'b0;
            else if (wb == `FRC_CMD_CLEAR)
            begin
              perr_q <= 1'b0;
              eerr_q <= 1'b0;
            end
            else
            begin
              perr_q <= 1'b1;
              eerr_q <= 1'b1;
            end
          end
        ST_PROG2:
          if (cmd_live)
          begin
            rsr_q <= 1'b1;
            if (!in_range || !blk_ok)
            begin
              perr_q <= 1'b1;
              eerr_q <= 1'b1;
              st_q   <= ST_IDLE;
            end
            else
            begin
              array_prog_q <= 1'b1;
              array_addr_q <= cmd_addr;
              array_data_q <= wb;
              op_erase_q   <= 1'b0;
              cnt_q        <= PROG_CYCLES[15:0];
              st_q         <= ST_BUSY;
            end
          end
        ST_ERAS2:
          if (cmd_live)
          begin
            if (wb == `FRC_CMD_READ)
            begin
              rsr_q <= 1'b0;
              st_q  <= ST_IDLE;
            end
            else if (wb != `FRC_CMD_CONFIRM || !in_range || !blk_ok)
            begin
              perr_q <= 1'b1;
              eerr_q <= 1'b1;
              rsr_q  <= 1'b1;
              st_q   <= ST_IDLE;
            end
            else
            begin
              array_erase_q <= 1'b1;
              array_addr_q  <= cmd_addr;
              op_erase_q    <= 1'b1;
              rsr_q         <= 1'b1;
              cnt_q         <= ERASE_CYCLES[15:0];
              st_q          <= ST_BUSY;
            end
          end
        default:
        begin
          cnt_q <= cnt_q - 16'h0001;
          if (pe_done[0])
          begin
            array_prog_q  <= 1'b0;
            array_erase_q <= 1'b0;
            st_q          <= ST_IDLE;
            if (fail_q && op_erase_q)
              eerr_q <= 1'b1;
            if (fail_q && !op_erase_q)
              perr_q <= 1'b1;
          end
        end
      endcase
    end
  end

  assign flash_access_en   = !stop_q && !busy;
  assign flash_low_current = stop_q && ena_q;
  assign flash_power_en    = !(sw_q && !ena_q) && !flash_low_current;
  assign cpu_hold          = busy && sel_q;
  assign read_status_mode  = rsr_q;

endmodule // flash_rewrite_control

// >>> flash_rewrite_control_properties.sv
// port-level checks for flash_rewrite_control
// assumes one clock clk and asynchronous active-low reset rstn
`timescale 1ns/100ps
module flash_rewrite_control_properties #(
  parameter PROG_CYCLES  = 500,
  parameter ERASE_CYCLES = 3000
) (
  // clock and reset
  input wire        clk,
  input wire        rstn,
  // bus responses
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // flash side
  input wire        array_prog_q,
  input wire        array_erase_q,
  input wire [15:0] array_addr_q,
  input wire        flash_access_en,
  input wire        flash_power_en,
  input wire        flash_low_current,
  input wire        cpu_hold
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire        busy = array_prog_q | array_erase_q;
  reg  [31:0] busy_q;
  // a hung auto operation shows as an overlong busy run
  always @(posedge clk or negedge rstn)
    if (!rstn)
      busy_q <= 32'h0;
    else
      busy_q <= busy ? busy_q + 32'h1 : 32'h0;
  property p_busy_len; busy_q <= PROG_CYCLES + ERASE_CYCLES + 4; endproperty
  a_busy_len: assert property (p_busy_len) else $error("auto operation overran");
  property p_busy_blocks; busy && $past(busy) |-> !flash_access_en; endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("access open while busy");
  property p_stop; flash_low_current |-> !flash_access_en && !flash_power_en; endproperty
  a_stop: assert property (p_stop) else $error("stop leaves flash active");
  // an operation still running when stop lands must be dropped on the next edge
  property p_stop_abort; flash_low_current |=> !array_prog_q && !array_erase_q; endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort operation");
  property p_hold; cpu_hold && $past(cpu_hold) |-> busy; endproperty
  a_hold: assert property (p_hold) else $error("cpu held while idle");
  property p_one_op; !(array_prog_q && array_erase_q); endproperty
  a_one_op: assert property (p_one_op) else $error("program and erase together");
  property p_addr; busy && $past(busy) |-> $stable(array_addr_q); endproperty
  a_addr: assert property (p_addr) else $error("target moved mid operation");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");
  property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read response repeated");
  c_erase: cover property (array_erase_q ##1 !array_erase_q);
  c_hold: cover property (cpu_hold);
  c_stop: cover property (flash_low_current);
  c_abort: cover property (array_prog_q && flash_low_current ##1 !array_prog_q);
endmodule // flash_rewrite_control_properties

bind flash_rewrite_control flash_rewrite_control_properties #(.PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) chk_u (.clk(clk), .rstn(rstn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .array_prog_q(array_prog_q), .array_erase_q(array_erase_q), .array_addr_q(array_addr_q),
  .flash_access_en(flash_access_en), .flash_power_en(flash_power_en),
  .flash_low_current(flash_low_current), .cpu_hold(cpu_hold));

// >>> flash_rewrite_control_tb_top.sv
// self-checking bench for flash_rewrite_control over axi4-lite
// assumes shortened auto operation times set through parameters
`timescale 1ns/100ps
`include "flash_rewrite_defines.vh"
module flash_rewrite_control_tb_top;
  reg         clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  reg         arv = 1'b0, rry = 1'b0, swm = 1'b0, fail_req = 1'b0;
  reg  [13:0] aw = 14'h0, ar = 14'h0;
  reg  [31:0] wd = 32'h0, v;
  reg  [1:0]  rsp, m_lk = 2'b11;
  wire        awr, wrd, bv, arr, rv, afail, prog, erase, acc, pwr, lowc, hold, rsm;
  wire [15:0] aadr;
  wire [7:0]  adat;
  wire [1:0]  br, rr;
  wire [31:0] rd;
  integer     miscompares = 0, comparisons = 0, cyc = 0, seed = 25524, r;
  integer     m_en = 0, m_unlk = 0, m_sel = 0;
  always #50 clk = ~clk;
  flash_rewrite_control #(.PROG_CYCLES(20), .ERASE_CYCLES(30)) dut_u (.clk(clk), .rstn(rstn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aw), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr), .stop_wait_mode(swm),
    .array_prog_q(prog), .array_erase_q(erase), .array_addr_q(aadr), .array_data_q(adat),
    .array_fail(afail), .flash_access_en(acc), .flash_power_en(pwr), .flash_low_current(lowc),
    .cpu_hold(hold), .read_status_mode(rsm));
  flash_array_model fam_u (.clk(clk), .prog(prog), .erase(erase), .fail_req(fail_req),
    .array_fail(afail));
  task chk(input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e)
      begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task summarize;
    begin
      if (miscompares == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [13:0] a, input [31:0] d);
    reg tb;
    begin
      tb = 0;
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      aw <= a;
      wd <= d;
      while (!tb)
      begin
        @(posedge clk);
        if (awv && awr) awv <= 1'b0;
        if (wv && wrd) wv <= 1'b0;
        if (bry && bv)
        begin
          tb = 1;
          rsp = br;
          bry <= 1'b0;
        end
      end
    end
  endtask
  task rd_(input [13:0] a);
    reg t;
    begin
      t = 0;
      @(posedge clk);
      arv <= 1'b1;
      rry <= 1'b1;
      ar <= a;
      while (!t)
      begin
        @(posedge clk);
        if (arv && arr) arv <= 1'b0;
        if (rry && rv)
        begin
          t = 1;
          v = rd;
          rsp = rr;
          rry <= 1'b0;
        end
      end
    end
  endtask
  // expected {erase error, program error} after a two-write command
  function [1:0] flags(input integer o, input integer b, input [7:0] d, input integer f);
    begin
      if (!m_en || (o == 2 && d == 8'hff))
        flags = 2'b00;
      else if ((o == 2 && d != 8'hd0) || b > 7 || (b < 2 && (!m_unlk || m_lk[b])))
        flags = 2'b11;
      else
        flags = f ? o[1:0] : 2'b00;
    end
  endfunction
  task op(input integer o, input integer b, input [7:0] d, input integer f);
    reg [1:0] e;
    reg       go;
    begin
      e = flags(o, b, d, f);
      go = m_en && e != 2'b11 && !(o == 2 && d == 8'hff);
      fail_req <= f[0];
      wr(`FRC_CMD_ADDR, {b[5:0], 18'h0, o == 1 ? `FRC_CMD_PROG : `FRC_CMD_ERASE});
      wr(`FRC_CMD_ADDR, {b[5:0], 10'h005, 8'h00, d});
      chk(32'({prog, erase, hold}), 32'({go && o == 1, go && o == 2, go && m_sel}));
      chk(32'(rsm), 32'(m_en && !(o == 2 && d == 8'hff)));
      if (go)
        chk(32'(aadr), 32'({b[5:0], 10'h005}));
      if (go && o == 1)
        chk(32'(adat), 32'(d));
      rd_(`FRC_STAT_ADDR);
      chk(32'(v[0]), 32'(!go));
      while (!v[0]) rd_(`FRC_STAT_ADDR);
      chk(32'(v[7:6]), 32'(e));
      wr(`FRC_CMD_ADDR, {24'h0, `FRC_CMD_CLEAR});
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_(`FRC_STAT_ADDR);
    chk(v, 32'h01);
    rd_(`FRC_MODE_ADDR);
    chk(v, 32'he0);
    op(1, 3, 8'h5a, 0);
    wr(`FRC_STAT_ADDR, 32'h2);
    wr(`FRC_STAT_ADDR, 32'h6);
    m_en = 1;
    m_unlk = 1;
    rd_(`FRC_STAT_ADDR);
    chk(v, 32'h07);
    wr(`FRC_CMD_ADDR, 32'h33);
    rd_(`FRC_STAT_ADDR);
    chk(v, 32'hc7);
    // status read mode shows the error pair through the command port
    wr(`FRC_CMD_ADDR, {24'h0, `FRC_CMD_STATUS});
    chk(32'(rsm), 32'h1);
    rd_(`FRC_CMD_ADDR);
    chk(v, 32'hc0);
    wr(`FRC_CMD_ADDR, {24'h0, `FRC_CMD_CLEAR});
    rd_(`FRC_STAT_ADDR);
    chk(v, 32'h07);
    wr(`FRC_CMD_ADDR, {24'h0, `FRC_CMD_READ});
    chk(32'(rsm), 32'h0);
    op(2, 0, 8'hd0, 0);
    wr(`FRC_MODE_ADDR, 32'he0);
    wr(`FRC_MODE_ADDR, 32'h80);
    m_lk = 2'b00;
    rd_(`FRC_MODE_ADDR);
    chk(v, 32'h80);
    r = $random(seed);
    op(1, 1, r[7:0], 0);
    op(2, 0, 8'hd0, 1);
    op(1, 2 + r[10:8] % 6, r[23:16], 1);
    op(2, 4, 8'h55, 0);
    op(2, 4, 8'hff, 0);
    op(1, 8, r[31:24], 0);
    wr(`FRC_MODE_ADDR, 32'h80);
    wr(`FRC_MODE_ADDR, 32'hc2);
    m_sel = 1;
    m_lk = 2'b10;
    op(1, 5, r[15:8], 0);
    wr(`FRC_STAT_ADDR, 32'h2);
    m_unlk = 0;
    op(1, 0, r[7:0], 0);
    // a program cut short by the stop bit: no error flag, ready again
    wr(`FRC_CMD_ADDR, {6'h06, 18'h0, `FRC_CMD_PROG});
    wr(`FRC_CMD_ADDR, {6'h06, 18'h0, r[7:0]});
    wr(`FRC_STAT_ADDR, 32'ha);
    @(posedge clk);
    chk(32'({lowc, acc, pwr, prog, hold}), 32'h10);
    m_en = 0;
    op(2, 3, 8'hd0, 0);
    wr(`FRC_STAT_ADDR, 32'h2);
    wr(`FRC_STAT_ADDR, 32'h0);
    rd_(`FRC_MODE_ADDR);
    chk(v, 32'h80);
    rd_(`FRC_STAT_ADDR);
    chk(v, 32'h01);
    swm <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(pwr), 32'h0);
    swm <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(pwr), 32'h1);
    rd_(14'h0100);
    chk(32'(rsp), 32'h2);
    summarize;
  end
endmodule // flash_rewrite_control_tb_top

// >>> flash_rewrite_defines.vh
// register offsets, field positions, command codes and timings for flash_rewrite_control
// assumes a 32-bit axi4-lite slave; each register is one aligned word, byte address = 4 * index
//
// Contract
// - ready/busy flag reads 0 while programming, erasing or erase-suspended, else 1.
// - flash commands are accepted only while rewrite-mode enable is 1.
// - low-block unlock at 0 refuses program and erase to blocks 0 and 1.
// - block 0 rewritable only with unlock 1 and block 0 write-lock 0.
// - block 1 rewritable only with unlock 1 and block 1 write-lock 0.
// - flash stop 1 resets control, lowers current and blocks all flash accesses; the code lowers current only while rewrite-mode enable is also 1.
// - stop or wait with rewrite disabled powers flash down and back automatically.
// - program error flag goes 1 when auto-program ends in error.
// - erase error flag goes 1 when auto-erase ends in error.
// - a wrongly written command sets both error flags.
// - erase second byte other than d0h or ffh is a command sequence error.
// - program or erase to a protected block is a command sequence error.
// - address outside flash during program or erase is a command sequence error.
// - failed auto-erase sets erase error only.
// - failed auto-program sets program error only.
// - ffh as erase second byte drops the first byte and enters read array.
// - mode select 1 is hold-while-rewriting, 0 is run-while-rewriting.
// - clearing rewrite-mode enable forces mode select and both write-locks to 0.
// - write-locks writable only in rewrite mode; set by 1, clear by 1 then 0.
// - clearing rewrite-mode enable also forces low-block unlock to 0.
// - command 50h clears both error flags.
`ifndef FLASH_REWRITE_DEFINES_VH
`define FLASH_REWRITE_DEFINES_VH

// register indices and byte addresses
`define FRC_MODE_IDX      12'h1b5
`define FRC_STAT_IDX      12'h1b7
`define FRC_CMD_IDX       12'h1b8
`define FRC_MODE_ADDR     14'h06d4
`define FRC_STAT_ADDR     14'h06dc
`define FRC_CMD_ADDR      14'h06e0

// status/control register fields
`define FRC_RDY_BIT       0
`define FRC_ENA_BIT       1
`define FRC_UNLK_BIT      2
`define FRC_STOP_BIT      3
`define FRC_PERR_BIT      6
`define FRC_EERR_BIT      7
// mode register fields
`define FRC_SEL_BIT       1
`define FRC_LK0_BIT       5
`define FRC_LK1_BIT       6
`define FRC_MODE_B7_BIT   7

// command codes
`define FRC_CMD_READ      8'hff
`define FRC_CMD_STATUS    8'h70
`define FRC_CMD_CLEAR     8'h50
`define FRC_CMD_PROG      8'h40
`define FRC_CMD_ERASE     8'h20
`define FRC_CMD_CONFIRM   8'hd0

// flash layout: blocks of 2^BLK_SHIFT bytes
`define FRC_ADDR_W        16
`define FRC_BLK_SHIFT     10

// auto operation times
`define FRC_PROG_TIME_US  50
`define FRC_ERASE_TIME_US 300
`define FRC_CLK_MHZ       10

`endif
